// ===== design/acd_pkg.sv
// Functional notes
// [R01] primary bit-clock low byte: zero means 512, one means 1, others literal
// [R02] secondary bit-clock low byte decodes like the primary one
// [R03] top bit joined with low byte reaches 511 at most below the zero case
// [R04] automatic clock detection replaces programmed bit-clock ratios
// [R05] six-bit N-M field: zero means 64, others literal; ignored under auto
// [R06] both low bytes and the N-M field reset to one
// [R07] reserved bits read zero; software writes only their reset values
// [R08] core enable bit 2 turns the N divider on
// [R09] core enable bit 1 turns the M divider on
// [R10] core enable bit 0 turns the PDM clock divider on
// [R11] bits 7 and 6 turn on ADC matching and ADC modulator dividers
// [R12] bits 5 and 4 turn on DAC matching and DAC modulator dividers
// [R13] bits 3 and 2 turn on primary and secondary bit-clock dividers
// [R14] bits 1 and 0 turn on primary and secondary frame dividers
// [R15] both enable registers reset to zero, all dividers off
// [R16] each bit-clock ratio takes its top bit from a separate input
// [R17] modulator ratio codes 0,1,2 give divide by 1,2,4; 3 reserved
// [R18] disabled divider holds output low, counter cleared; else ratio cycles per period
// [R19] ratio changes are taken only at a period boundary
package acd_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PRI_LOW  = 8'h3C;
  localparam logic [7:0] OFS_SEC_LOW  = 8'h3D;
  localparam logic [7:0] OFS_NM       = 8'h3E;
  localparam logic [7:0] OFS_CORE_EN  = 8'h44;
  localparam logic [7:0] OFS_CONV_EN  = 8'h45;
  localparam logic [7:0] RST_LOW      = 8'h01;
  localparam logic [7:0] RST_NM       = 8'h01;
  localparam logic [7:0] RST_EN       = 8'h00;
  localparam logic [7:0] NM_MASK      = 8'h3F;
  localparam logic [7:0] CORE_MASK    = 8'h07;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_N_ON       = 2;
  localparam int BIT_M_ON       = 1;
  localparam int BIT_PDM_ON     = 0;
  localparam int BIT_ADC_MATCH  = 7;
  localparam int BIT_ADC_MOD    = 6;
  localparam int BIT_DAC_MATCH  = 5;
  localparam int BIT_DAC_MOD    = 4;
  localparam int BIT_PRI_BCLK   = 3;
  localparam int BIT_SEC_BCLK   = 2;
  localparam int BIT_PRI_FRAME  = 1;
  localparam int BIT_SEC_FRAME  = 0;
  // ---------------------------------------------------------------
  // divider ratios
  // ---------------------------------------------------------------
  localparam int RATIO_W = 10;
  localparam logic [RATIO_W-1:0] BITCLK_ZERO_RATIO = 10'h200;
  localparam logic [RATIO_W-1:0] NM_ZERO_RATIO     = 10'h040;
  localparam logic [RATIO_W-1:0] RATIO_ONE         = 10'h001;
  localparam logic [RATIO_W-1:0] RATIO_TWO         = 10'h002;
  localparam logic [RATIO_W-1:0] RATIO_FOUR        = 10'h004;
  localparam int DIV_PRI = 0;
  localparam int DIV_SEC = 1;
  localparam int DIV_NM  = 2;
  localparam int DIV_ADC = 3;
  localparam int DIV_DAC = 4;
  localparam int DIV_NUM = 5;

  function automatic logic [RATIO_W-1:0] bitclk_ratio(input logic top, input logic [7:0] low);
    logic [8:0] code;
    code = {top, low};
    if (code == 9'h000) begin
      bitclk_ratio = BITCLK_ZERO_RATIO;
    end else begin
      bitclk_ratio = {1'b0, code};
    end
  endfunction

  function automatic logic [RATIO_W-1:0] nm_ratio(input logic [5:0] code);
    if (code == 6'h00) begin
      nm_ratio = NM_ZERO_RATIO;
    end else begin
      nm_ratio = {4'h0, code};
    end
  endfunction

  function automatic logic [RATIO_W-1:0] mod_ratio(input logic [1:0] code);
    case (code)
      2'h1:    mod_ratio = RATIO_TWO;
      2'h2:    mod_ratio = RATIO_FOUR;
      default: mod_ratio = RATIO_ONE;
    endcase
  endfunction
endpackage

// ===== design/acd_div_if.sv
`timescale 1ns/1ps
interface acd_div_if
  import acd_pkg::*;
  ();
  logic               en;
  logic [RATIO_W-1:0] ratio;
  logic               tick;
  logic               lvl;
  modport ctrl (output en, output ratio, input tick, input lvl);
  modport div  (input en, input ratio, output tick, output lvl);
endinterface

// ===== design/acd_divider.sv
`timescale 1ns/1ps
module acd_divider
  import acd_pkg::*;
  (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // divider control
  acd_div_if.div    d
);
  typedef struct packed {
    logic [RATIO_W-1:0] cnt;
    logic [RATIO_W-1:0] ratio;
    logic               run;
    logic               lvl;
    logic               tick;
  } acd_div_state_t;

  acd_div_state_t st_r;
  acd_div_state_t st_nxt;
  logic [RATIO_W:0] half;
  logic [RATIO_W-1:0] cnt_inc;

  // ---------------------------------------------------------------
  // period counter
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    st_nxt.tick = 1'b0;
    half     = ({1'b0, st_r.ratio} + 11'h001) >> 1;
    cnt_inc  = st_r.cnt + RATIO_ONE;
    if (!d.en) begin
      st_nxt.cnt   = '0; // [R18]
      st_nxt.run   = 1'b0;
      st_nxt.lvl   = 1'b0; // [R18]
      st_nxt.ratio = d.ratio;
    end else if (!st_r.run || (st_r.cnt == st_r.ratio - RATIO_ONE)) begin
      st_nxt.cnt   = '0;
      st_nxt.ratio = d.ratio; // [R19]
      st_nxt.run   = 1'b1;
      st_nxt.tick  = 1'b1; // [R18]
      st_nxt.lvl   = 1'b1;
    end else begin
      st_nxt.cnt   = cnt_inc;
      st_nxt.lvl   = ({1'b0, cnt_inc} < half);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign d.tick = st_r.tick;
  assign d.lvl  = st_r.lvl;
endmodule

// ===== design/acd_clock_config.sv
`timescale 1ns/1ps
module acd_clock_config
  import acd_pkg::*;
  (
  // clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               ARST_N,
  // register port
  input  wire logic [7:0]         REG_ADDR,
  input  wire logic               REG_WR,
  input  wire logic [7:0]         REG_WDATA,
  input  wire logic               REG_RD,
  output logic      [7:0]         REG_RDATA,
  // neighbouring fields
  input  wire logic               PRIMARY_BITCLK_RATIO_TOP,
  input  wire logic               SECONDARY_BITCLK_RATIO_TOP,
  input  wire logic [1:0]         ADC_MODULATOR_RATIO,
  input  wire logic [1:0]         DAC_MODULATOR_RATIO,
  // automatic clock detection
  input  wire logic               AUTO_DETECT_EN,
  input  wire logic [RATIO_W-1:0] AUTO_PRI_BITCLK_RATIO,
  input  wire logic [RATIO_W-1:0] AUTO_SEC_BITCLK_RATIO,
  input  wire logic [RATIO_W-1:0] AUTO_NM_RATIO,
  // divider enables to the clock tree
  output logic                    N_DIVIDER_ON,
  output logic                    M_DIVIDER_ON,
  output logic                    PDM_CLOCK_DIVIDER_ON,
  output logic                    ADC_MATCHING_DIVIDER_ON,
  output logic                    DAC_MATCHING_DIVIDER_ON,
  output logic                    PRIMARY_FRAME_DIVIDER_ON,
  output logic                    SECONDARY_FRAME_DIVIDER_ON,
  // divided clocks
  output logic                    PRIMARY_BITCLK_CLK,
  output logic                    PRIMARY_BITCLK_TICK,
  output logic                    SECONDARY_BITCLK_CLK,
  output logic                    SECONDARY_BITCLK_TICK,
  output logic                    ANALOG_NM_CLK,
  output logic                    ANALOG_NM_TICK,
  output logic                    ADC_MODULATOR_CLK,
  output logic                    ADC_MODULATOR_TICK,
  output logic                    DAC_MODULATOR_CLK,
  output logic                    DAC_MODULATOR_TICK
);
  typedef struct packed {
    logic [7:0] pri_low;
    logic [7:0] sec_low;
    logic [7:0] nm;
    logic [7:0] core_en;
    logic [7:0] conv_en;
    logic [7:0] rdata;
  } acd_cfg_state_t;

  acd_cfg_state_t    st_r;
  acd_cfg_state_t    st_nxt;
  logic [1:0]        rst_sync_r;
  logic              rst_n;
  logic [DIV_NUM-1:0] div_en;
  logic [RATIO_W-1:0] div_ratio [DIV_NUM];
  logic [DIV_NUM-1:0] div_tick;
  logic [DIV_NUM-1:0] div_lvl;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (REG_WR) begin
      case (REG_ADDR)
        OFS_PRI_LOW: st_nxt.pri_low = REG_WDATA; // [R01]
        OFS_SEC_LOW: st_nxt.sec_low = REG_WDATA; // [R02]
        OFS_NM:      st_nxt.nm      = REG_WDATA & NM_MASK; // [R07]
        OFS_CORE_EN: st_nxt.core_en = REG_WDATA & CORE_MASK; // [R07]
        OFS_CONV_EN: st_nxt.conv_en = REG_WDATA;
        default:     st_nxt.rdata   = st_nxt.rdata;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_PRI_LOW: st_nxt.rdata = st_r.pri_low;
        OFS_SEC_LOW: st_nxt.rdata = st_r.sec_low;
        OFS_NM:      st_nxt.rdata = st_r.nm & NM_MASK; // [R07]
        OFS_CORE_EN: st_nxt.rdata = st_r.core_en & CORE_MASK; // [R07]
        OFS_CONV_EN: st_nxt.rdata = st_r.conv_en;
        default:     st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r.pri_low <= RST_LOW; // [R06]
      st_r.sec_low <= RST_LOW; // [R06]
      st_r.nm      <= RST_NM; // [R06]
      st_r.core_en <= RST_EN; // [R15]
      st_r.conv_en <= RST_EN; // [R15]
      st_r.rdata   <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;

  // ---------------------------------------------------------------
  // enables
  // ---------------------------------------------------------------
  assign N_DIVIDER_ON               = st_r.core_en[BIT_N_ON]; // [R08]
  assign M_DIVIDER_ON               = st_r.core_en[BIT_M_ON]; // [R09]
  assign PDM_CLOCK_DIVIDER_ON       = st_r.core_en[BIT_PDM_ON]; // [R10]
  assign ADC_MATCHING_DIVIDER_ON    = st_r.conv_en[BIT_ADC_MATCH]; // [R11]
  assign DAC_MATCHING_DIVIDER_ON    = st_r.conv_en[BIT_DAC_MATCH]; // [R12]
  assign PRIMARY_FRAME_DIVIDER_ON   = st_r.conv_en[BIT_PRI_FRAME]; // [R14]
  assign SECONDARY_FRAME_DIVIDER_ON = st_r.conv_en[BIT_SEC_FRAME]; // [R14]

  assign div_en[DIV_PRI] = st_r.conv_en[BIT_PRI_BCLK]; // [R13]
  assign div_en[DIV_SEC] = st_r.conv_en[BIT_SEC_BCLK]; // [R13]
  assign div_en[DIV_NM]  = st_r.core_en[BIT_N_ON] & st_r.core_en[BIT_M_ON];
  assign div_en[DIV_ADC] = st_r.conv_en[BIT_ADC_MOD]; // [R11]
  assign div_en[DIV_DAC] = st_r.conv_en[BIT_DAC_MOD]; // [R12]

  // ---------------------------------------------------------------
  // ratio selection
  // ---------------------------------------------------------------
  always_comb begin
    if (AUTO_DETECT_EN) begin
      div_ratio[DIV_PRI] = AUTO_PRI_BITCLK_RATIO; // [R04]
      div_ratio[DIV_SEC] = AUTO_SEC_BITCLK_RATIO; // [R04]
      div_ratio[DIV_NM]  = AUTO_NM_RATIO; // [R05]
    end else begin
      div_ratio[DIV_PRI] = bitclk_ratio(PRIMARY_BITCLK_RATIO_TOP, st_r.pri_low); // [R16] [R03]
      div_ratio[DIV_SEC] = bitclk_ratio(SECONDARY_BITCLK_RATIO_TOP, st_r.sec_low); // [R16]
      div_ratio[DIV_NM]  = nm_ratio(st_r.nm[5:0]); // [R05]
    end
    div_ratio[DIV_ADC] = mod_ratio(ADC_MODULATOR_RATIO); // [R17]
    div_ratio[DIV_DAC] = mod_ratio(DAC_MODULATOR_RATIO); // [R17]
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DIV_NUM; i++) begin : g_div
    acd_div_if link ();
    assign link.en     = div_en[i];
    assign link.ratio  = div_ratio[i];
    assign div_tick[i] = link.tick;
    assign div_lvl[i]  = link.lvl;
    acd_divider u_div (
      .clk   (SYS_CLK),
      .rst_n (rst_n),
      .d     (link.div)
    );
  end

  assign PRIMARY_BITCLK_CLK    = div_lvl[DIV_PRI];
  assign PRIMARY_BITCLK_TICK   = div_tick[DIV_PRI];
  assign SECONDARY_BITCLK_CLK  = div_lvl[DIV_SEC];
  assign SECONDARY_BITCLK_TICK = div_tick[DIV_SEC];
  assign ANALOG_NM_CLK         = div_lvl[DIV_NM];
  assign ANALOG_NM_TICK        = div_tick[DIV_NM];
  assign ADC_MODULATOR_CLK     = div_lvl[DIV_ADC];
  assign ADC_MODULATOR_TICK    = div_tick[DIV_ADC];
  assign DAC_MODULATOR_CLK     = div_lvl[DIV_DAC];
  assign DAC_MODULATOR_TICK    = div_tick[DIV_DAC];
endmodule

// ===== tb/acd_chk.sv
`timescale 1ns/1ps
module acd_chk
  import acd_pkg::*;
  (
  // clock, reset and register port
  input wire logic               SYS_CLK,
  input wire logic               ARST_N,
  input wire logic [7:0]         REG_ADDR,
  input wire logic               REG_WR,
  input wire logic [7:0]         REG_WDATA,
  input wire logic               REG_RD,
  input wire logic [7:0]         REG_RDATA,
  // ratio inputs
  input wire logic [1:0]         ADC_MODULATOR_RATIO,
  input wire logic [1:0]         DAC_MODULATOR_RATIO,
  input wire logic               AUTO_DETECT_EN,
  input wire logic [RATIO_W-1:0] AUTO_PRI_BITCLK_RATIO,
  // enables and divided clocks
  input wire logic               N_DIVIDER_ON,
  input wire logic               M_DIVIDER_ON,
  input wire logic               PDM_CLOCK_DIVIDER_ON,
  input wire logic               ADC_MATCHING_DIVIDER_ON,
  input wire logic               DAC_MATCHING_DIVIDER_ON,
  input wire logic               PRIMARY_FRAME_DIVIDER_ON,
  input wire logic               SECONDARY_FRAME_DIVIDER_ON,
  input wire logic               PRIMARY_BITCLK_CLK,
  input wire logic               PRIMARY_BITCLK_TICK,
  input wire logic               ADC_MODULATOR_CLK,
  input wire logic               ADC_MODULATOR_TICK,
  input wire logic               DAC_MODULATOR_CLK,
  input wire logic               DAC_MODULATOR_TICK
);
  // -------------------------------------------------------------
  // shadow of enable registers
  // -------------------------------------------------------------
  logic [7:0] core_r;
  logic [7:0] conv_r;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      core_r <= RST_EN;
      conv_r <= RST_EN;
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_CORE_EN) core_r <= REG_WDATA;
      if (REG_ADDR == OFS_CONV_EN) conv_r <= REG_WDATA;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_pri_auto3;
    PRIMARY_BITCLK_TICK && AUTO_DETECT_EN && $stable(AUTO_DETECT_EN)
      && AUTO_PRI_BITCLK_RATIO == 10'h003 && $stable(AUTO_PRI_BITCLK_RATIO);
  endsequence
  sequence s_adc4;
    ADC_MODULATOR_TICK && ADC_MODULATOR_RATIO == 2'h2 && $stable(ADC_MODULATOR_RATIO);
  endsequence
  AST_CONV_ON: assert property (
    {ADC_MATCHING_DIVIDER_ON, DAC_MATCHING_DIVIDER_ON, PRIMARY_FRAME_DIVIDER_ON,
    SECONDARY_FRAME_DIVIDER_ON} == {conv_r[7], conv_r[5], conv_r[1:0]})
    else $error("converter enable outputs differ from register");
  AST_CORE_ON: assert property (
    {N_DIVIDER_ON, M_DIVIDER_ON, PDM_CLOCK_DIVIDER_ON} == core_r[2:0])
    else $error("core enable outputs differ from register");
  AST_PRI_QUIET: assert property (!conv_r[BIT_PRI_BCLK] [*2] |->
    !PRIMARY_BITCLK_CLK && !PRIMARY_BITCLK_TICK) else $error("disabled bit clock not quiet");
  AST_PRI_START: assert property ($rose(conv_r[BIT_PRI_BCLK]) |=>
    PRIMARY_BITCLK_TICK && PRIMARY_BITCLK_CLK) else $error("bit clock did not start");
  AST_PRI_AUTO: assert property (s_pri_auto3 ##0 conv_r[BIT_PRI_BCLK] [*3] |->
    ##1 PRIMARY_BITCLK_TICK && !$past(PRIMARY_BITCLK_TICK)) else $error("auto ratio period wrong");
  AST_ADC_FOUR: assert property (s_adc4 ##0 conv_r[BIT_ADC_MOD] [*4] |->
    ##1 ADC_MODULATOR_TICK && !$past(ADC_MODULATOR_CLK)) else $error("modulator by four wrong");
  AST_DAC_ONE: assert property (DAC_MODULATOR_TICK && DAC_MODULATOR_RATIO == 2'h0
    && $stable(DAC_MODULATOR_RATIO) && conv_r[BIT_DAC_MOD] |=> DAC_MODULATOR_TICK
    && DAC_MODULATOR_CLK) else $error("modulator by one wrong");
  AST_RD_CORE: assert property (REG_RD && REG_ADDR == OFS_CORE_EN |=>
    REG_RDATA == ($past(core_r) & CORE_MASK)) else $error("core enable read wrong");
endmodule

bind acd_clock_config acd_chk u_chk (.*);

// ===== tb/acd_clock_config_test.sv
`timescale 1ns/1ps
module acd_clock_config_test
  import acd_pkg::*;
  ;
  logic               SYS_CLK;
  logic               ARST_N = 1'b0;
  logic [7:0]         REG_ADDR = 8'h00;
  logic [7:0]         REG_WDATA = 8'h00;
  logic               REG_WR = 1'b0;
  logic               REG_RD = 1'b0;
  logic [7:0]         REG_RDATA;
  logic [1:0]         adc_r = 2'h0;
  logic [1:0]         dac_r = 2'h0;
  logic [1:0]         top_r = 2'h0;
  logic               auto_r = 1'b0;
  logic [RATIO_W-1:0] ap_r = 10'h001;
  logic [RATIO_W-1:0] as_r = 10'h001;
  logic [RATIO_W-1:0] an_r = 10'h001;
  wire  [6:0]         on;
  wire  [4:0]         tk;
  wire  [4:0]         ck;
  int                 n_mismatch = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  acd_clock_config DUT (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PRIMARY_BITCLK_RATIO_TOP(top_r[0]), .SECONDARY_BITCLK_RATIO_TOP(top_r[1]),
    .ADC_MODULATOR_RATIO(adc_r), .DAC_MODULATOR_RATIO(dac_r), .AUTO_DETECT_EN(auto_r),
    .AUTO_PRI_BITCLK_RATIO(ap_r), .AUTO_SEC_BITCLK_RATIO(as_r), .AUTO_NM_RATIO(an_r),
    .N_DIVIDER_ON(on[2]), .M_DIVIDER_ON(on[1]), .PDM_CLOCK_DIVIDER_ON(on[0]),
    .ADC_MATCHING_DIVIDER_ON(on[3]), .DAC_MATCHING_DIVIDER_ON(on[4]),
    .PRIMARY_FRAME_DIVIDER_ON(on[5]), .SECONDARY_FRAME_DIVIDER_ON(on[6]),
    .PRIMARY_BITCLK_CLK(ck[0]), .PRIMARY_BITCLK_TICK(tk[0]), .SECONDARY_BITCLK_CLK(ck[1]),
    .SECONDARY_BITCLK_TICK(tk[1]), .ANALOG_NM_CLK(ck[2]), .ANALOG_NM_TICK(tk[2]),
    .ADC_MODULATOR_CLK(ck[3]), .ADC_MODULATOR_TICK(tk[3]), .DAC_MODULATOR_CLK(ck[4]),
    .DAC_MODULATOR_TICK(tk[4]));
  // -------------------------------------------------------------
  // clock, timeout and helpers
  // -------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(negedge SYS_CLK);
    chk("rdata", e, REG_RDATA);
  endtask
  task automatic meas(input int s, input int e);
    int n;
    int h;
    n = 0;
    h = 0;
    do begin
      @(negedge SYS_CLK);
      n++;
    end while (tk[s] !== 1'b1 && n < 600);
    n = 0;
    do begin
      h += ck[s];
      @(negedge SYS_CLK);
      n++;
    end while (tk[s] !== 1'b1 && n < 600);
    chk("period", 16'(e), 16'(n));
    chk("high time", 16'((e + 1) / 2), 16'(h));
  endtask
  task automatic bc(input int p, input logic t, input logic [7:0] l);
    wr(OFS_CONV_EN, 8'h00);
    if (p == 0) begin
      top_r[0] <= t;
    end else begin
      top_r[1] <= t;
    end
    wr(8'(OFS_PRI_LOW + p), l);
    wr(OFS_CONV_EN, (p == 0) ? 8'h08 : 8'h04);
  endtask
  function automatic int bexp(input logic t, input logic [7:0] l);
    return ({t, l} == 9'h000) ? 512 : int'({t, l});
  endfunction
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] lows [6];
    logic       tops [6];
    void'($urandom(85206));
    repeat (10) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    rd(OFS_PRI_LOW, RST_LOW);
    rd(OFS_SEC_LOW, RST_LOW);
    rd(OFS_NM, RST_NM);
    rd(OFS_CORE_EN, RST_EN);
    rd(OFS_CONV_EN, RST_EN);
    chk("enables", 16'h0000, on);
    rd(8'h46, 8'h00);
    wr(OFS_NM, 8'hFF);
    rd(OFS_NM, 8'h3F);
    wr(OFS_CORE_EN, 8'hFF);
    rd(OFS_CORE_EN, 8'h07);
    for (int i = 0; i < 16; i++) begin
      d = (i < 8) ? 8'(1 << i) : 8'($urandom);
      wr(OFS_CONV_EN, d);
      @(negedge SYS_CLK);
      chk("enables", {d[0], d[1], d[5], d[7], 3'h7}, on);
      rd(OFS_CONV_EN, d);
    end
    lows = '{8'h00, 8'h01, 8'h02, 8'hFF, 8'h00, 8'($urandom_range(3, 255))};
    tops = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'($urandom)};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        bc(p, tops[i], lows[i]);
        meas(p, bexp(tops[i], lows[i]));
      end
    end
    lows = '{8'h00, 8'h01, 8'h02, 8'h3F, 8'($urandom_range(3, 62)), 8'h05};
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CORE_EN, 8'h00);
      wr(OFS_NM, lows[i]);
      wr(OFS_CORE_EN, 8'h06);
      meas(2, (lows[i] == 8'h00) ? 64 : int'(lows[i]));
    end
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CONV_EN, 8'h00);
      adc_r <= 2'(c);
      dac_r <= 2'(c);
      wr(OFS_CONV_EN, 8'h50);
      meas(3, (c == 1) ? 2 : (c == 2) ? 4 : 1);
      meas(4, (c == 1) ? 2 : (c == 2) ? 4 : 1);
    end
    // ratio change in mid-period waits for the boundary
    wr(OFS_CONV_EN, 8'h00);
    adc_r <= 2'h2;
    wr(OFS_CONV_EN, 8'h40);
    @(posedge SYS_CLK);
    adc_r <= 2'h1;
    meas(3, 4);
    meas(3, 2);
    wr(OFS_CONV_EN, 8'h00);
    auto_r <= 1'b1;
    ap_r <= 10'h003;
    as_r <= 10'($urandom_range(1, 40));
    an_r <= 10'h005;
    bc(0, 1'b1, 8'h55);
    meas(0, 3);
    bc(1, 1'b0, 8'h09);
    meas(1, int'(as_r));
    wr(OFS_CORE_EN, 8'h00);
    wr(OFS_CORE_EN, 8'h06);
    meas(2, 5);
    @(posedge SYS_CLK);
    ARST_N <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    chk("enables", 16'h0000, on);
    ARST_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    rd(OFS_CONV_EN, RST_EN);
    wrap_up;
  end
endmodule
